// File: inc/tfh_pkg.sv
// constants, types and timing for the token flag host controller
package tfh_pkg;
   localparam int TFH_CLK_PERIOD_NS = 10;
   // slowest speed grade access and write pulse of the flag space
   localparam int TFH_ACCESS_NS = 15;
   localparam int TFH_WRITE_NS = 15;
   localparam int TFH_SYNC_STAGES = 2;
   localparam int TFH_DATA_W = 18;
   localparam int TFH_IDX_W = 3;
   localparam int TFH_CNT_W = 4;
   localparam logic [3:0] TFH_NUM_FLAGS = 4'H8;
   localparam logic [2:0] TFH_FIRST_IDX = 3'H0;
   localparam logic [2:0] TFH_LAST_IDX = 3'H7;
   localparam logic TFH_FLAG_REQUEST = 1'H0;
   localparam logic TFH_FLAG_FREE = 1'H1;

   function automatic int tfh_ceil_cycles(input int ns);
      return (ns + TFH_CLK_PERIOD_NS - 1) / TFH_CLK_PERIOD_NS;
   endfunction : tfh_ceil_cycles

   localparam logic [3:0] TFH_WR_CYC = 4'(tfh_ceil_cycles(TFH_WRITE_NS));
   // access time plus the two synchroniser stages before sampling
   localparam logic [3:0] TFH_RD_CYC = 4'(tfh_ceil_cycles(TFH_ACCESS_NS) + TFH_SYNC_STAGES);
   localparam logic [3:0] TFH_GAP_CYC = 4'H1;
   localparam logic [3:0] TFH_ACQ_POLLS = 4'H4;
   localparam logic [3:0] TFH_CNT_ZERO = 4'H0;
   localparam logic [3:0] TFH_CNT_LAST = 4'H1;

   typedef enum logic [1:0] {
      TFH_OP_TEST,
      TFH_OP_ACQUIRE,
      TFH_OP_RELEASE,
      TFH_OP_INIT
   } tfh_op_t;

   typedef enum logic [2:0] {
      TFH_ST_IDLE,
      TFH_ST_WSETUP,
      TFH_ST_WPULSE,
      TFH_ST_WHOLD,
      TFH_ST_RPULSE,
      TFH_ST_GAP,
      TFH_ST_DONE
   } tfh_state_t;
endpackage : tfh_pkg

// File: rtl/tfh_sync.sv
// two-stage synchroniser for the flag data pins
`timescale 1ns/10ps
module tfh_sync #(
   parameter int WIDTH = 18
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         meta <= '0;
         sync_out <= '0;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule : tfh_sync

// File: rtl/tfh_host.sv
// host controller driving one port of a dual-port memory's token flag space
//
// Operation
// [RL1] Device holds eight token flags with per-port request latches, apart from memory.
// [RL2] Flags active low: write zero to request, write one to release.
// [RL3] Flag access uses flag select low plus write, byte selects, output enable.
// [RL4] Memory chip enable stays high during every flag access.
// [RL5] Only the three lowest address lines choose the flag.
// [RL6] Device takes the written value from data bit zero only.
// [RL7] Zero on a free flag: writer reads zero, other port reads one.
// [RL8] Owner writing one frees the flag unless the other port is pending.
// [RL9] Non-owner zero waits in its request latch; that port reads one.
// [RL10] Release with pending request hands ownership straight to the other port.
// [RL11] Reads drive all eighteen outputs; writes use data line zero.
// [RL12] Read value is replicated onto every data bit.
// [RL13] Read value latched when select, byte select and output enable go active.
// [RL14] Poller must drop flag select or output enable between reads.
// [RL15] Byte selects only gate read outputs, never the flag state.
// [RL16] Acquire by writing zero first, then reading back to verify.
// [RL17] After a failed request keep reading or write one to withdraw.
// [RL18] Contending requests: earlier wins, exact ties settle to one port.
// [RL19] No automatic init; each port writes one to every flag at start.
// [RL20] Clocked device resolves same-cycle requests by fixed priority, left first.
// [RL21] Clocked device may reset all request latches to free.
`timescale 1ns/10ps
module tfh_host
   import tfh_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic cmd_valid,
   input tfh_op_t cmd_op,
   input wire logic [TFH_IDX_W-1:0] cmd_index,
   output logic cmd_ready,
   output logic done,
   output logic result_owned,
   output logic flag_space_select_n,
   output logic chip_enable_n,
   output logic write_n,
   output logic output_enable_n,
   output logic lower_byte_select_n,
   output logic upper_byte_select_n,
   output logic [TFH_IDX_W-1:0] flag_index_lines,
   input wire logic [TFH_DATA_W-1:0] data_in,
   output logic [TFH_DATA_W-1:0] data_out,
   output logic data_oe_n
);
   tfh_state_t state, next_state;
   tfh_op_t op;
   logic [TFH_CNT_W-1:0] cnt;
   logic [TFH_CNT_W-1:0] polls, next_polls;
   logic [TFH_IDX_W-1:0] idx, next_idx;
   logic wr_val, next_wr_val;
   logic last_was_write;
   logic owned;
   logic init_pending;
   logic [TFH_DATA_W-1:0] data_sync;

   function automatic logic [TFH_CNT_W-1:0] load_count(input tfh_state_t st);
      unique case (st)
         TFH_ST_WPULSE: return TFH_WR_CYC;
         TFH_ST_RPULSE: return TFH_RD_CYC;
         TFH_ST_GAP: return TFH_GAP_CYC;
         default: return TFH_CNT_ZERO;
      endcase
   endfunction : load_count

   tfh_sync #(.WIDTH(TFH_DATA_W)) u_sync (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .async_in(data_in),
      .sync_out(data_sync)
   );

   always_comb begin
      next_state = state;
      next_idx = idx;
      next_wr_val = wr_val;
      next_polls = polls;
      unique case (state)
         TFH_ST_IDLE: begin
            if (init_pending) begin
               next_state = TFH_ST_WSETUP; // RL19
               next_idx = TFH_FIRST_IDX;
               next_wr_val = TFH_FLAG_FREE;
            end else if (cmd_valid && cmd_ready) begin
               // init always sweeps every flag, whatever index came with it
               next_idx = (cmd_op == TFH_OP_INIT) ? TFH_FIRST_IDX : cmd_index;
               next_polls = TFH_ACQ_POLLS;
               // acquire writes zero before any read
               next_wr_val = (cmd_op == TFH_OP_ACQUIRE) ? TFH_FLAG_REQUEST : TFH_FLAG_FREE; // RL16
               next_state = (cmd_op == TFH_OP_TEST) ? TFH_ST_RPULSE : TFH_ST_WSETUP;
            end
         end
         TFH_ST_WSETUP: next_state = TFH_ST_WPULSE;
         TFH_ST_WPULSE: begin
            if (cnt == TFH_CNT_LAST) begin
               next_state = TFH_ST_WHOLD;
            end
         end
         TFH_ST_WHOLD: next_state = TFH_ST_GAP;
         TFH_ST_RPULSE: begin
            if (cnt == TFH_CNT_LAST) begin
               next_state = TFH_ST_GAP; // RL14
            end
         end
         TFH_ST_GAP: begin
            if (cnt == TFH_CNT_LAST) begin
               next_state = TFH_ST_DONE;
               if (last_was_write) begin
                  if (op == TFH_OP_INIT && idx != TFH_LAST_IDX) begin
                     next_state = TFH_ST_WSETUP; // RL19
                     next_idx = idx + 3'H1;
                  end else if (op == TFH_OP_ACQUIRE && wr_val == TFH_FLAG_REQUEST) begin
                     next_state = TFH_ST_RPULSE; // RL16
                  end
               end else if (op == TFH_OP_ACQUIRE && !owned) begin
                  // a stale request would seize the token later, so never leave it
                  if (polls != TFH_CNT_ZERO) begin
                     next_state = TFH_ST_RPULSE; // RL17
                     next_polls = polls - 4'H1;
                  end else begin
                     next_state = TFH_ST_WSETUP; // RL17
                     next_wr_val = TFH_FLAG_FREE;
                  end
               end
            end
         end
         TFH_ST_DONE: next_state = TFH_ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state <= TFH_ST_IDLE;
         idx <= TFH_FIRST_IDX;
         wr_val <= TFH_FLAG_FREE;
         polls <= TFH_CNT_ZERO;
      end else begin
         state <= next_state;
         idx <= next_idx;
         wr_val <= next_wr_val;
         polls <= next_polls;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cnt <= TFH_CNT_ZERO;
      end else if (next_state != state) begin
         cnt <= load_count(next_state);
      end else if (cnt != TFH_CNT_ZERO) begin
         cnt <= cnt - 4'H1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         op <= TFH_OP_TEST;
         init_pending <= 1'H1;
      end else if (state == TFH_ST_IDLE && next_state != TFH_ST_IDLE) begin
         op <= init_pending ? TFH_OP_INIT : cmd_op;
         init_pending <= 1'H0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         last_was_write <= 1'H0;
         owned <= 1'H0;
      end else begin
         if (state == TFH_ST_WSETUP) begin
            last_was_write <= 1'H1;
         end else if (state == TFH_ST_RPULSE) begin
            last_was_write <= 1'H0;
         end
         // all bits low means this port holds the token
         if (state == TFH_ST_RPULSE && cnt == TFH_CNT_LAST) begin
            owned <= ~|data_sync; // RL12
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         cmd_ready <= 1'H0;
         done <= 1'H0;
         result_owned <= 1'H0;
      end else begin
         cmd_ready <= (next_state == TFH_ST_IDLE) && !init_pending;
         done <= (next_state == TFH_ST_DONE);
         if (next_state == TFH_ST_DONE) begin
            result_owned <= (op == TFH_OP_TEST || op == TFH_OP_ACQUIRE) && owned;
         end
      end
   end

   // pins follow next_state so they stand registered in step with the state
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         flag_space_select_n <= 1'H1;
         chip_enable_n <= 1'H1;
         write_n <= 1'H1;
         output_enable_n <= 1'H1;
         lower_byte_select_n <= 1'H1;
         upper_byte_select_n <= 1'H1;
         flag_index_lines <= TFH_FIRST_IDX;
         data_out <= '0;
         data_oe_n <= 1'H1;
      end else begin
         flag_space_select_n <= !(next_state inside {TFH_ST_WSETUP, TFH_ST_WPULSE,
            TFH_ST_WHOLD, TFH_ST_RPULSE}); // RL3
         chip_enable_n <= 1'H1; // RL4
         write_n <= (next_state != TFH_ST_WPULSE); // RL2
         output_enable_n <= (next_state != TFH_ST_RPULSE); // RL14
         lower_byte_select_n <= !(next_state inside {TFH_ST_WSETUP, TFH_ST_WPULSE,
            TFH_ST_WHOLD, TFH_ST_RPULSE});
         upper_byte_select_n <= (next_state != TFH_ST_RPULSE);
         flag_index_lines <= next_idx;
         data_out <= {TFH_DATA_W{next_wr_val}}; // RL6
         data_oe_n <= !(next_state inside {TFH_ST_WSETUP, TFH_ST_WPULSE, TFH_ST_WHOLD});
      end
   end

   // helper state read only by the assertions
   logic [3:0] init_writes;
   logic acq_wrote;
   logic last_wr_val;
   always_ff @(posedge ref_clk) begin
      if (sys_rst || state == TFH_ST_IDLE) begin
         init_writes <= 4'H0;
         acq_wrote <= 1'H0;
         last_wr_val <= TFH_FLAG_FREE;
      end else begin
         // the device takes the write as write_n rises, which is the hold cycle
         if (state == TFH_ST_WHOLD && op == TFH_OP_INIT) begin
            init_writes <= init_writes + 4'H1;
         end
         if (!write_n) begin
            last_wr_val <= data_out[0];
            if (data_out[0] == TFH_FLAG_REQUEST) begin
               acq_wrote <= 1'H1;
            end
         end
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   AST_CE_HIGH: assert property (!flag_space_select_n |-> chip_enable_n) // RL4
      else $error("chip enable low during flag access");
   AST_STROBE_IN_SPACE: assert property ((!write_n || !output_enable_n)
      |-> !flag_space_select_n) // RL3
      else $error("strobe active outside flag space");
   AST_READ_RELEASE: assert property ($rose(output_enable_n) |-> flag_space_select_n) // RL14
      else $error("flag select not dropped after read");
   AST_READ_LEN: assert property ($fell(output_enable_n)
      |-> !output_enable_n [*4] ##1 output_enable_n) // RL14
      else $error("read pulse length wrong");
   AST_WRITE_LEN: assert property ($fell(write_n) |-> !write_n [*2] ##1 write_n) // RL2
      else $error("write pulse length wrong");
   AST_NO_CONTENTION: assert property (!output_enable_n |-> data_oe_n) // RL11
      else $error("host drives data while reading");
   AST_ACQ_WRITE_FIRST: assert property ((state == TFH_ST_RPULSE && op == TFH_OP_ACQUIRE)
      |-> acq_wrote) // RL16
      else $error("acquire read before request write");
   AST_FAIL_WITHDRAW: assert property ((state == TFH_ST_DONE && op == TFH_OP_ACQUIRE
      && !owned) |-> last_wr_val == TFH_FLAG_FREE && !result_owned) // RL17
      else $error("failed acquire left request pending");
   AST_INIT_ALL: assert property ((state == TFH_ST_DONE && op == TFH_OP_INIT)
      |-> init_writes == TFH_NUM_FLAGS && last_wr_val == TFH_FLAG_FREE) // RL19
      else $error("init did not free every flag");
   AST_DONE_BOUND: assert property ((cmd_valid && cmd_ready) |-> ##[1:200] done) // RL16
      else $error("command never completed");

   COV_ACQ_WON: cover property (done && op == TFH_OP_ACQUIRE && result_owned);
   COV_ACQ_WITHDRAWN: cover property (done && op == TFH_OP_ACQUIRE && !result_owned);
   COV_RELEASE: cover property (done && op == TFH_OP_RELEASE);
   COV_TEST_FREE: cover property (done && op == TFH_OP_TEST && !result_owned);
endmodule : tfh_host

// File: bench/tfh_flag_model.sv
// behavioural model of the token flag device: host port pins plus a second port for the bench
`timescale 1ns/10ps
module tfh_flag_model
   import tfh_pkg::*;
(
   input wire logic ref_clk,
   input wire logic flag_space_select_n,
   input wire logic chip_enable_n,
   input wire logic write_n,
   input wire logic output_enable_n,
   input wire logic lower_byte_select_n,
   input wire logic upper_byte_select_n,
   input wire logic [TFH_IDX_W-1:0] flag_index_lines,
   input wire logic [TFH_DATA_W-1:0] data_out,
   input wire logic data_oe_n,
   output logic [TFH_DATA_W-1:0] data_in,
   input wire logic b_wr,
   input wire logic [TFH_IDX_W-1:0] b_idx,
   input wire logic b_d0,
   output logic [7:0] a_flag,
   output logic [7:0] b_flag
);
   // no reset pin: power-up leaves stale host requests, so only software init frees them
   logic [7:0] req_a = 8'H00;
   logic [7:0] req_b = 8'HFF;
   logic [7:0] own_a = 8'H00;
   logic [7:0] own_b = 8'H00;
   logic prev_wn = 1'H1;
   logic lat = 1'H1;
   logic [TFH_DATA_W-1:0] rel = 18'H00000;
   wire logic a_sel = !flag_space_select_n && chip_enable_n;
   wire logic rd_act = a_sel && !output_enable_n && !(lower_byte_select_n && upper_byte_select_n);
   assign a_flag = ~own_a;
   assign b_flag = ~own_b;
   always @(posedge ref_clk) begin
      if (a_sel && !prev_wn && write_n && !data_oe_n) begin
         req_a[flag_index_lines] = data_out[0];
      end
      prev_wn = write_n;
      if (b_wr) begin
         req_b[b_idx] = b_d0;
      end
      for (int i = 0; i < 8; i++) begin
         if (own_a[i] && req_a[i]) own_a[i] = 1'b0;
         if (own_b[i] && req_b[i]) own_b[i] = 1'b0;
         // left wins a same-cycle tie; pending requests wait in req_* until freed
         if (!own_a[i] && !own_b[i]) begin
            if (!req_a[i]) own_a[i] = 1'b1;
            else if (!req_b[i]) own_b[i] = 1'b1;
         end
      end
   end
   // index may move in the same step as output enable, so let it settle first
   always @(posedge rd_act) begin
      #1;
      lat = a_flag[flag_index_lines];
   end
   // released bus shows the inverse, so a stale read never passes
   always @(negedge rd_act) begin
      rel = ~{TFH_DATA_W{lat}};
   end
   assign data_in = rd_act ? {TFH_DATA_W{lat}} : rel;
endmodule : tfh_flag_model

// File: bench/tfh_host_test.sv
// self-checking bench for the token flag host controller against the device model
`timescale 1ns/10ps
module tfh_host_test
   import tfh_pkg::*;
;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cmd_valid = 1'b0;
   tfh_op_t cmd_op = TFH_OP_TEST;
   logic [TFH_IDX_W-1:0] cmd_index = 3'H0;
   logic cmd_ready, done, result_owned, flag_space_select_n, chip_enable_n, write_n;
   logic output_enable_n, lower_byte_select_n, upper_byte_select_n, data_oe_n;
   logic [TFH_IDX_W-1:0] flag_index_lines;
   logic [TFH_DATA_W-1:0] data_in, data_out;
   logic b_wr = 1'b0;
   logic [TFH_IDX_W-1:0] b_idx = 3'H0;
   logic b_d0 = 1'b1;
   logic [7:0] a_flag, b_flag;
   logic own;
   int checks = 0;
   int failures = 0;
   always #5 ref_clk = ~ref_clk;
   tfh_host dut_u (.ref_clk, .sys_rst, .cmd_valid, .cmd_op, .cmd_index, .cmd_ready, .done,
      .result_owned, .flag_space_select_n, .chip_enable_n, .write_n, .output_enable_n,
      .lower_byte_select_n, .upper_byte_select_n, .flag_index_lines, .data_in, .data_out,
      .data_oe_n);
   tfh_flag_model model_u (.ref_clk, .flag_space_select_n, .chip_enable_n, .write_n,
      .output_enable_n, .lower_byte_select_n, .upper_byte_select_n, .flag_index_lines,
      .data_out, .data_oe_n, .data_in, .b_wr, .b_idx, .b_d0, .a_flag, .b_flag);
   task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish
   task automatic wait_done();
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         #1;
         n++;
      end while (done !== 1'b1 && n < 200);
      if (done !== 1'b1) begin
         failures++;
         tally_and_finish();
      end
   endtask : wait_done
   task automatic run_cmd(input tfh_op_t op, input logic [2:0] idx, output logic owned);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 100) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      if (cmd_ready !== 1'b1) begin
         failures++;
         tally_and_finish();
      end
      @(posedge ref_clk);
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_index <= idx;
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
      wait_done();
      owned = result_owned;
      check("chip_enable_n", chip_enable_n, 1'b1);
   endtask : run_cmd
   // the far port bypasses the device's pin protocol: one-cycle b_wr strobe, data bit zero only
   task automatic b_write(input logic [2:0] idx, input logic v);
      @(posedge ref_clk);
      b_wr <= 1'b1;
      b_idx <= idx;
      b_d0 <= v;
      @(posedge ref_clk);
      b_wr <= 1'b0;
      #1;
   endtask : b_write
   task automatic t_reset_init();
      wait_done();
      check("host view", a_flag, 8'HFF);
      check("far view", b_flag, 8'HFF);
      $display("test reset_init done");
   endtask : t_reset_init
   task automatic t_handover();
      run_cmd(TFH_OP_ACQUIRE, 3'H3, own);
      check("acquire owned", own, 1'b1);
      check("far view", b_flag[3], 1'b1);
      b_write(3'H3, 1'b0);
      run_cmd(TFH_OP_TEST, 3'H3, own);
      check("still owned", own, 1'b1);
      check("far pending", b_flag[3], 1'b1);
      run_cmd(TFH_OP_RELEASE, 3'H3, own);
      check("release result", own, 1'b0);
      check("far owns", b_flag[3], 1'b0);
      $display("test handover done");
   endtask : t_handover
   task automatic t_fail_withdraw();
      run_cmd(TFH_OP_ACQUIRE, 3'H3, own);
      check("failed acquire", own, 1'b0);
      b_write(3'H3, 1'b1);
      check("far free", b_flag[3], 1'b1);
      check("host free", a_flag[3], 1'b1);
      $display("test fail_withdraw done");
   endtask : t_fail_withdraw
   task automatic t_all_flags();
      for (int i = 0; i < 8; i++) begin
         run_cmd(TFH_OP_ACQUIRE, 3'(i), own);
         check("acquire each", own, 1'b1);
         check("one flag only", a_flag, 8'(~(8'H01 << i)));
         run_cmd(TFH_OP_RELEASE, 3'(i), own);
         check("released", a_flag, 8'HFF);
      end
      $display("test all_flags done");
   endtask : t_all_flags
   task automatic t_init_cmd();
      run_cmd(TFH_OP_ACQUIRE, 3'H2, own);
      b_write(3'H6, 1'b0);
      run_cmd(TFH_OP_INIT, 3'H4, own);
      check("init host", a_flag, 8'HFF);
      check("init far", b_flag, 8'HBF);
      run_cmd(TFH_OP_TEST, 3'H6, own);
      check("test far owned", own, 1'b0);
      b_write(3'H6, 1'b1);
      $display("test init_cmd done");
   endtask : t_init_cmd
   initial begin
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      t_reset_init();
      t_handover();
      t_fail_withdraw();
      t_all_flags();
      t_init_cmd();
      tally_and_finish();
   end
endmodule : tfh_host_test
